/* File: core/fsp_pkg.sv */
/*
 Shared constants and types for the flash status and protection block.
 Assumes a 100 MHz system clock and a separate serial link clock.
*/
package fsp_pkg;
   // System clock and status-write busy time
   localparam int CLK_PERIOD_NS = 10;
   localparam int SR_WRITE_NS = 200;
   localparam int SR_WRITE_CYCLES = (SR_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SR_CNT_W = $clog2(SR_WRITE_CYCLES + 1);

   // Status word bit positions
   localparam int BIT_BUSY = 0;
   localparam int BIT_LATCH = 1;
   localparam int BIT_GUARD_LSB = 2;
   localparam int BIT_SR_GUARD_LOW = 7;
   localparam int BIT_SR_GUARD_HIGH = 8;
   localparam int BIT_QUAD = 9;
   localparam int BIT_LOCK0 = 10;
   localparam int BIT_LOCK1 = 11;
   localparam int BIT_DUMMY = 12;
   localparam int BIT_INVERT = 14;
   localparam int BIT_SUSPEND = 15;

   // Non-volatile field masks and defaults
   localparam logic [15:0] NV_MASK = 16'h5ffc;
   localparam logic [15:0] LOCK_MASK = 16'h0c00;
   localparam logic [15:0] NV_RESET = 16'h0000;

   // Dual I/O read dummy cycles
   localparam logic [3:0] DUMMY_CYCLES_LOW = 4'h4;
   localparam logic [3:0] DUMMY_CYCLES_HIGH = 4'h8;

   // Array geometry in bytes
   localparam logic [23:0] ARRAY_BYTES = 24'h080000;
   localparam logic [23:0] PAGE_BYTES = 24'h000100;
   localparam logic [23:0] SECTOR_BYTES = 24'h001000;
   localparam logic [23:0] BLOCK32_BYTES = 24'h008000;
   localparam logic [23:0] BLOCK64_BYTES = 24'h010000;

   typedef enum logic [3:0] {
      NO_CMD,
      LATCH_SET_CMD,
      LATCH_CLEAR_CMD,
      STATUS_WRITE_CMD,
      STATUS_READ_CMD,
      PAGE_PROGRAM_CMD,
      SECTOR_ERASE_CMD,
      BLOCK32_ERASE_CMD,
      BLOCK64_ERASE_CMD,
      CHIP_ERASE_CMD,
      SECURITY_PROGRAM_CMD,
      SECURITY_ERASE_CMD,
      SUSPEND_CMD,
      RESUME_CMD,
      SOFT_RESET_CMD
   } fsp_cmd_t;

   typedef struct packed {
      fsp_cmd_t code;
      logic [23:0] addr;
      logic [15:0] data;
   } fsp_cmd_word_t;
endpackage

/* File: core/fsp_sync_bit.sv */
/*
 Two flip-flop level synchroniser.
 Assumes the input is a level that stays put for at least two clock edges.
*/
`timescale 1ns/100ps
module fsp_sync_bit
   import fsp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Level in and out
   input wire logic levelIn,
   output logic levelOut
);
   typedef struct packed {
      logic stage1;
      logic stage2;
   } fsp_sync_state_t;

   fsp_sync_state_t state_reg;
   fsp_sync_state_t state_next;

   always_comb begin
      state_next.stage1 = levelIn;
      state_next.stage2 = state_reg.stage1;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign levelOut = state_reg.stage2;
endmodule

/* File: core/fsp_link_port.sv */
/*
 Link-clock side of the command handshake.
 Assumes the system side answers each request toggle with an ack toggle
 and holds the status snapshot steady from that toggle until the next request.
*/
`timescale 1ns/100ps
module fsp_link_port
   import fsp_pkg::*;
(
   // Link clock and reset
   input wire logic linkClk,
   input wire logic rst_b,
   // Command from the serial decoder
   input wire logic cmdValid,
   input wire fsp_cmd_word_t cmdIn,
   output logic cmdReady,
   // Answer to the serial decoder
   output logic rspValid,
   output logic [15:0] rspStatus,
   // Toward the system domain
   output logic reqToggle,
   output fsp_cmd_word_t cmdHold,
   input wire logic ackToggle,
   input wire logic [15:0] statusSnap
);
   typedef struct packed {
      logic reqToggle;
      logic ackSeen;
      logic pending;
      logic ready;
      logic rspValid;
      logic [15:0] rspStatus;
      fsp_cmd_word_t cmdHold;
   } fsp_link_state_t;

   fsp_link_state_t state_reg;
   fsp_link_state_t state_next;
   logic ackSync;

   fsp_sync_bit ackSyncer (
      .clk(linkClk),
      .rst_b(rst_b),
      .levelIn(ackToggle),
      .levelOut(ackSync)
   );

   // Command word is held still until the ack returns
   always_comb begin
      state_next = state_reg;
      state_next.rspValid = 1'b0;
      if (!state_reg.pending && cmdValid) begin
         state_next.cmdHold = cmdIn;
         state_next.reqToggle = ~state_reg.reqToggle;
         state_next.pending = 1'b1;
      end else if (state_reg.pending && ackSync != state_reg.ackSeen) begin
         state_next.ackSeen = ackSync;
         state_next.pending = 1'b0;
         state_next.rspValid = 1'b1;
         state_next.rspStatus = statusSnap;
      end
      state_next.ready = !state_next.pending;
   end

   always_ff @(posedge linkClk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= '0;
         state_reg.ready <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign cmdReady = state_reg.ready;
   assign rspValid = state_reg.rspValid;
   assign rspStatus = state_reg.rspStatus;
   assign reqToggle = state_reg.reqToggle;
   assign cmdHold = state_reg.cmdHold;
endmodule

/* File: core/fsp_status_regs.sv */
/*
 Status registers and write protection of a serial NOR flash.
 Assumes a serial command decoder on the link clock, an array engine on
 the system clock that pulses opDone, and a non-volatile store that
 presents its contents on nvStored and saves nvValue on nvCommit.
*/
// What this block does
// RULE1 - Busy flag shows program, erase, status write
// RULE2 - Clear write latch refuses writes and erases
// RULE3 - Block guard bits change by status write
// RULE4 - Refuse program or erase inside guarded region
// RULE5 - Block guard changes blocked under hardware protection
// RULE6 - Chip erase only with empty guard region
// RULE7 - Guard bits 00: write with latch set
// RULE8 - Guard bits 01: pin low locks register
// RULE9 - Guard bits 10: locked until power cycle
// RULE10 - Guard bits 11: status register locked forever
// RULE11 - Quad enable turns shared pins into data
// RULE12 - Host keeps quad off with tied pins
// RULE13 - Security lock bits only ever set
// RULE14 - Set lock makes security area read-only
// RULE15 - Dummy select picks four or eight cycles
// RULE16 - Suspend flag volatile, bit 13 reserved
// RULE17 - Latch set by command, cleared by writes
// RULE18 - Low guard pin protects guard bits
// RULE19 - Invert bit protects the complement region
// RULE20 - Suspend set by suspend, cleared by resume
// RULE21 - Status write deferred until busy ends
`timescale 1ns/100ps
module fsp_status_regs
   import fsp_pkg::*;
(
   // System clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Link clock and serial decoder side
   input wire logic linkClk,
   input wire logic cmdValid,
   input wire fsp_cmd_word_t cmdIn,
   output logic cmdReady,
   output logic rspValid,
   output logic [15:0] rspStatus,
   // Write guard pin
   input wire logic writeGuardB,
   // Array engine
   output logic opStart,
   output fsp_cmd_t opCode,
   output logic [23:0] opAddr,
   input wire logic opDone,
   // Non-volatile store
   input wire logic [15:0] nvStored,
   output logic nvCommit,
   output logic [15:0] nvValue,
   // Status and configuration
   output logic [7:0] statusLow,
   output logic [7:0] statusHigh,
   output logic pinsAsData,
   output logic [3:0] dualDummyCycles,
   output logic securityReadOnly,
   output logic cmdRefused
);
   typedef struct packed {
      logic loaded;
      logic [15:0] nvBits;
      logic [15:0] srPending;
      logic latch;
      logic suspended;
      logic arrayBusy;
      logic srBusy;
      logic [SR_CNT_W-1:0] srCount;
      logic reqSeen;
      logic ackToggle;
      logic [15:0] statusSnap;
      logic [15:0] statusOut;
      logic opStart;
      fsp_cmd_t opCode;
      logic [23:0] opAddr;
      logic nvCommit;
      logic [3:0] dummyCycles;
      logic cmdRefused;
   } fsp_sys_state_t;

   fsp_sys_state_t state_reg;
   fsp_sys_state_t state_next;

   logic reqToggle;
   logic reqSync;
   logic guardPinHigh;
   fsp_cmd_word_t cmdHold;

   fsp_link_port linkPort (
      .linkClk(linkClk),
      .rst_b(rst_b),
      .cmdValid(cmdValid),
      .cmdIn(cmdIn),
      .cmdReady(cmdReady),
      .rspValid(rspValid),
      .rspStatus(rspStatus),
      .reqToggle(reqToggle),
      .cmdHold(cmdHold),
      .ackToggle(state_reg.ackToggle),
      .statusSnap(state_reg.statusSnap)
   );

   fsp_sync_bit reqSyncer (
      .clk(clk_sys),
      .rst_b(rst_b),
      .levelIn(reqToggle),
      .levelOut(reqSync)
   );

   fsp_sync_bit pinSyncer (
      .clk(clk_sys),
      .rst_b(rst_b),
      .levelIn(writeGuardB),
      .levelOut(guardPinHigh)
   );

   // One address against the guard code
   function automatic logic addrGuarded(logic [23:0] addr, logic [15:0] nv);
      logic [4:0] code;
      logic [23:0] size;
      logic whole;
      logic empty;
      logic hit;
      code = nv[BIT_GUARD_LSB +: 5];
      size = '0;
      whole = 1'b0;
      empty = 1'b0;
      if (code[2:0] == 3'h0) begin
         empty = 1'b1;
      end else if (!code[4]) begin
         if (code[2]) begin
            whole = 1'b1;
         end else begin
            size = BLOCK64_BYTES << (code[1:0] - 2'h1);
         end
      end else if (code[2:0] == 3'h7) begin
         whole = 1'b1;
      end else if (code[2]) begin
         size = BLOCK32_BYTES;
      end else begin
         size = SECTOR_BYTES << (code[1:0] - 2'h1);
      end
      if (code[3]) begin
         hit = addr < size;
      end else begin
         hit = addr >= (ARRAY_BYTES - size);
      end
      hit = whole | (!empty & hit);
      return hit ^ nv[BIT_INVERT]; // see RULE19
   endfunction

   // Guarded regions sit at one end, so the two ends of a span decide
   function automatic logic spanGuarded(logic [23:0] addr, logic [23:0] size,
                                        logic [15:0] nv);
      logic [23:0] first;
      logic [23:0] last;
      first = addr & ~(size - 24'h1) & (ARRAY_BYTES - 24'h1);
      last = first + size - 24'h1;
      return addrGuarded(first, nv) | addrGuarded(last, nv);
   endfunction

   always_comb begin
      logic take;
      logic busy;
      logic srOpen;
      logic chipOk;
      logic locked;
      logic guarded;
      logic [23:0] span;
      logic [1:0] srGuard;
      logic [15:0] word;
      take = 1'b0;
      busy = 1'b0;
      srOpen = 1'b0;
      chipOk = 1'b0;
      locked = 1'b0;
      guarded = 1'b0;
      span = PAGE_BYTES;
      srGuard = 2'h0;
      word = '0;

      state_next = state_reg;
      state_next.opStart = 1'b0;
      state_next.nvCommit = 1'b0;
      state_next.cmdRefused = 1'b0;

      // Stored bits are read one cycle after reset, not during it
      if (!state_reg.loaded) begin
         state_next.loaded = 1'b1;
         state_next.nvBits = nvStored & NV_MASK;
         if (nvStored[BIT_SR_GUARD_HIGH] && !nvStored[BIT_SR_GUARD_LOW]) begin
            state_next.nvBits[BIT_SR_GUARD_HIGH] = 1'b0; // see RULE9
         end
      end

      // Status write takes effect only when its busy time ends
      if (state_reg.srBusy) begin
         if (state_reg.srCount <= SR_CNT_W'(1)) begin
            state_next.srBusy = 1'b0;
            state_next.srCount = '0;
            state_next.nvBits = state_reg.srPending; // see RULE21
            state_next.nvCommit = 1'b1;
         end else begin
            state_next.srCount = state_reg.srCount - SR_CNT_W'(1);
         end
      end

      if (state_reg.arrayBusy && opDone) begin
         state_next.arrayBusy = 1'b0;
      end

      busy = state_reg.arrayBusy | state_reg.srBusy;
      srGuard = {state_reg.nvBits[BIT_SR_GUARD_HIGH], state_reg.nvBits[BIT_SR_GUARD_LOW]};
      // Guard pin function is lost while the pin carries data
      case (srGuard)
         2'h0: srOpen = 1'b1; // see RULE7
         2'h1: srOpen = pinsAsData | guardPinHigh; // see RULE8, RULE18, RULE5
         2'h2: srOpen = 1'b0; // see RULE9
         2'h3: srOpen = 1'b0; // see RULE10
         default: srOpen = 1'b0;
      endcase
      chipOk = (state_reg.nvBits[4:2] == 3'h0 && !state_reg.nvBits[BIT_INVERT])
         || (state_reg.nvBits[4:2] == 3'h7 && state_reg.nvBits[BIT_INVERT]); // see RULE6
      locked = |(state_reg.nvBits & LOCK_MASK); // see RULE14
      case (cmdHold.code)
         SECTOR_ERASE_CMD: span = SECTOR_BYTES;
         BLOCK32_ERASE_CMD: span = BLOCK32_BYTES;
         BLOCK64_ERASE_CMD: span = BLOCK64_BYTES;
         default: span = PAGE_BYTES;
      endcase
      guarded = spanGuarded(cmdHold.addr, span, state_reg.nvBits); // see RULE4

      take = state_reg.loaded && (reqSync != state_reg.reqSeen);
      if (take) begin
         state_next.reqSeen = reqSync;
         state_next.ackToggle = ~state_reg.ackToggle;
         case (cmdHold.code)
            STATUS_READ_CMD: begin
            end
            LATCH_SET_CMD: begin
               if (busy) begin
                  state_next.cmdRefused = 1'b1;
               end else begin
                  state_next.latch = 1'b1; // see RULE17
               end
            end
            LATCH_CLEAR_CMD: begin
               if (busy) begin
                  state_next.cmdRefused = 1'b1;
               end else begin
                  state_next.latch = 1'b0; // see RULE17
               end
            end
            STATUS_WRITE_CMD: begin
               if (state_reg.latch && !busy && srOpen) begin // see RULE2, RULE21
                  state_next.latch = 1'b0; // see RULE17
                  state_next.srBusy = 1'b1;
                  state_next.srCount = SR_CNT_W'(SR_WRITE_CYCLES);
                  // Lock bits only ever set; volatile and reserved bits dropped
                  state_next.srPending = (cmdHold.data & NV_MASK)
                     | (state_reg.nvBits & LOCK_MASK); // see RULE3, RULE13, RULE16
               end else begin
                  state_next.cmdRefused = 1'b1;
               end
            end
            PAGE_PROGRAM_CMD, SECTOR_ERASE_CMD, BLOCK32_ERASE_CMD, BLOCK64_ERASE_CMD: begin
               if (state_reg.latch && !busy && !state_reg.suspended && !guarded) begin
                  state_next.latch = 1'b0; // see RULE17
                  state_next.arrayBusy = 1'b1; // see RULE1
                  state_next.opStart = 1'b1;
                  state_next.opCode = cmdHold.code;
                  state_next.opAddr = cmdHold.addr;
               end else begin
                  state_next.cmdRefused = 1'b1; // see RULE2, RULE4
               end
            end
            CHIP_ERASE_CMD: begin
               if (state_reg.latch && !busy && !state_reg.suspended && chipOk) begin
                  state_next.latch = 1'b0; // see RULE17
                  state_next.arrayBusy = 1'b1;
                  state_next.opStart = 1'b1;
                  state_next.opCode = cmdHold.code;
                  state_next.opAddr = '0;
               end else begin
                  state_next.cmdRefused = 1'b1; // see RULE6
               end
            end
            SECURITY_PROGRAM_CMD, SECURITY_ERASE_CMD: begin
               if (state_reg.latch && !busy && !state_reg.suspended && !locked) begin
                  state_next.latch = 1'b0;
                  state_next.arrayBusy = 1'b1;
                  state_next.opStart = 1'b1;
                  state_next.opCode = cmdHold.code;
                  state_next.opAddr = cmdHold.addr;
               end else begin
                  state_next.cmdRefused = 1'b1; // see RULE14
               end
            end
            SUSPEND_CMD: begin
               if (state_reg.arrayBusy && !opDone) begin
                  state_next.suspended = 1'b1; // see RULE20
                  state_next.arrayBusy = 1'b0;
                  state_next.opStart = 1'b1;
                  state_next.opCode = SUSPEND_CMD;
               end else begin
                  state_next.cmdRefused = 1'b1;
               end
            end
            RESUME_CMD: begin
               if (state_reg.suspended) begin
                  state_next.suspended = 1'b0; // see RULE20
                  state_next.arrayBusy = 1'b1;
                  state_next.opStart = 1'b1;
                  state_next.opCode = RESUME_CMD;
               end else begin
                  state_next.cmdRefused = 1'b1;
               end
            end
            SOFT_RESET_CMD: begin
               // Non-volatile bits survive; only volatile state drops
               state_next.latch = 1'b0; // see RULE17
               state_next.suspended = 1'b0; // see RULE20
            end
            default: begin
               state_next.cmdRefused = 1'b1;
            end
         endcase
      end

      // Visible status built from the next state so reads are current
      word = state_next.nvBits & NV_MASK;
      word[BIT_BUSY] = state_next.arrayBusy | state_next.srBusy; // see RULE1
      word[BIT_LATCH] = state_next.latch; // see RULE2
      word[BIT_SUSPEND] = state_next.suspended; // see RULE16
      state_next.statusOut = word;
      if (take) begin
         state_next.statusSnap = word;
      end
      if (state_next.nvBits[BIT_DUMMY]) begin
         state_next.dummyCycles = DUMMY_CYCLES_HIGH; // see RULE15
      end else begin
         state_next.dummyCycles = DUMMY_CYCLES_LOW;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= '0;
         state_reg.nvBits <= NV_RESET;
         state_reg.srPending <= NV_RESET;
         state_reg.opCode <= NO_CMD;
         state_reg.dummyCycles <= DUMMY_CYCLES_LOW;
      end else begin
         state_reg <= state_next;
      end
   end

   assign opStart = state_reg.opStart;
   assign opCode = state_reg.opCode;
   assign opAddr = state_reg.opAddr;
   assign nvCommit = state_reg.nvCommit;
   assign nvValue = state_reg.nvBits;
   assign statusLow = state_reg.statusOut[7:0];
   assign statusHigh = state_reg.statusOut[15:8];
   assign pinsAsData = state_reg.nvBits[BIT_QUAD]; // see RULE11
   assign dualDummyCycles = state_reg.dummyCycles;
   assign securityReadOnly = |(state_reg.nvBits & LOCK_MASK);
   assign cmdRefused = state_reg.cmdRefused;
endmodule

/* File: dv/fsp_engine_model.sv */
/*
 Array engine and non-volatile store facing the status block.
 Assumes opStart pulses one clk_sys cycle; the store survives rst_b.
*/
`timescale 1ns/100ps
module fsp_engine_model
   import fsp_pkg::*;
#(
   parameter int OP_CYCLES = 60
)
(
   // Clock
   input wire logic clk_sys,
   // Array engine
   input wire logic opStart,
   input wire fsp_cmd_t opCode,
   output logic opDone,
   // Store
   input wire logic nvCommit,
   input wire logic [15:0] nvValue,
   output logic [15:0] nvStored
);
   int cnt;
   logic run;

   // Stored lock-down code must not survive power-up
   initial begin
      opDone = 1'b0;
      nvStored = 16'h0100;
      run = 1'b0;
      cnt = 0;
   end

   // Suspend halts the count; resume restarts a full op, slow on purpose
   always @(posedge clk_sys) begin
      opDone <= 1'b0;
      if (nvCommit)
         nvStored <= nvValue;
      if (opStart) begin
         run <= (opCode != SUSPEND_CMD);
         cnt <= 0;
      end else if (run) begin
         cnt <= cnt + 1;
         if (cnt == OP_CYCLES - 1) begin
            opDone <= 1'b1;
            run <= 1'b0;
         end
      end
   end
endmodule

/* File: dv/fsp_status_regs_sva.sv */
/*
 Port checker for the status and protection block.
 Assumes it is bound onto the top module; clk_sys domain only.
*/
`timescale 1ns/100ps
module fsp_status_regs_sva
   import fsp_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Pin and engine
   input wire logic writeGuardB,
   input wire logic opStart,
   input wire fsp_cmd_t opCode,
   // Store
   input wire logic nvCommit,
   input wire logic [15:0] nvValue,
   // Status
   input wire logic [7:0] statusLow,
   input wire logic [7:0] statusHigh,
   input wire logic pinsAsData,
   input wire logic [3:0] dualDummyCycles,
   input wire logic securityReadOnly
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   property p_commit_busy;
      nvCommit |-> $past(statusLow[0]);
   endproperty
   a_commit_busy: assert property (p_commit_busy) else $error("commit outside busy");

   property p_op_busy;
      opStart && opCode != SUSPEND_CMD |-> ##[0:1] statusLow[0];
   endproperty
   a_op_busy: assert property (p_op_busy) else $error("op without busy");

   property p_latch_drop;
      opStart && opCode inside {PAGE_PROGRAM_CMD, SECTOR_ERASE_CMD, BLOCK32_ERASE_CMD,
         BLOCK64_ERASE_CMD, CHIP_ERASE_CMD} |-> ##[0:2] !statusLow[1];
   endproperty
   a_latch_drop: assert property (p_latch_drop) else $error("latch kept");

   property p_chip;
      opStart && opCode == CHIP_ERASE_CMD |-> (statusLow[4:2] == 3'h0 && !statusHigh[6])
         || (statusLow[4:2] == 3'h7 && statusHigh[6]);
   endproperty
   a_chip: assert property (p_chip) else $error("chip erase under guard");

   property p_locked;
      nvCommit |-> !$past(statusHigh[0]);
   endproperty
   a_locked: assert property (p_locked) else $error("write while locked");

   property p_pin;
      nvCommit && $past(statusLow[7]) && !$past(statusHigh[0]) && !$past(statusHigh[1])
         |-> $past(writeGuardB, 22);
   endproperty
   a_pin: assert property (p_pin) else $error("write with pin low");

   property p_volatile;
      nvCommit |-> (nvValue & ~NV_MASK) == 16'h0000;
   endproperty
   a_volatile: assert property (p_volatile) else $error("volatile bit stored");

   property p_lock_sticky;
      (statusHigh[3:2] & $past(statusHigh[3:2])) == $past(statusHigh[3:2]);
   endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");

   property p_config;
      pinsAsData == statusHigh[1] && securityReadOnly == (|statusHigh[3:2]) && !statusHigh[5]
         && dualDummyCycles == (statusHigh[4] ? DUMMY_CYCLES_HIGH : DUMMY_CYCLES_LOW);
   endproperty
   a_config: assert property (p_config) else $error("config mismatch");
endmodule

bind fsp_status_regs fsp_status_regs_sva u_sva (.clk_sys, .rst_b, .writeGuardB, .opStart,
   .opCode, .nvCommit, .nvValue, .statusLow, .statusHigh, .pinsAsData, .dualDummyCycles,
   .securityReadOnly);

/* File: dv/fsp_status_regs_test.sv */
/*
 Command-level bench for the status and protection block.
 Assumes the engine model answers ops and keeps the stored word.
*/
`timescale 1ns/100ps
module fsp_status_regs_test
   import fsp_pkg::*;
;
   logic clk_sys = 1'b0, linkClk = 1'b0, rst_b = 1'b0, cmdValid = 1'b0, writeGuardB = 1'b1;
   fsp_cmd_word_t cmdIn = '0;
   logic cmdReady, rspValid, opStart, opDone, nvCommit, pinsAsData, securityReadOnly;
   logic cmdRefused;
   logic [15:0] rspStatus, nvStored, nvValue, rsp;
   logic [7:0] statusLow, statusHigh;
   logic [3:0] dualDummyCycles;
   logic [23:0] opAddr;
   fsp_cmd_t opCode;
   int fails = 0, n_compared = 0, busyCnt = 0, refusals = 0;

   fsp_status_regs DUT (.clk_sys, .rst_b, .linkClk, .cmdValid, .cmdIn, .cmdReady, .rspValid,
      .rspStatus, .writeGuardB, .opStart, .opCode, .opAddr, .opDone, .nvStored, .nvCommit,
      .nvValue, .statusLow, .statusHigh, .pinsAsData, .dualDummyCycles, .securityReadOnly,
      .cmdRefused);
   fsp_engine_model u_eng (.clk_sys, .opStart, .opCode, .opDone, .nvCommit, .nvValue,
      .nvStored);

   initial forever #5 clk_sys = ~clk_sys;
   // Three link edges fall inside the opening reset
   initial begin
      #7 linkClk = 1'b1;
      forever #15 linkClk = ~linkClk;
   end
   // Sampled mid-cycle, away from the launching edge
   always @(negedge clk_sys) if (statusLow[0] === 1'b1) busyCnt++;
   always @(negedge clk_sys) if (cmdRefused === 1'b1) refusals++;

   task automatic results();
      $display("compared %0d mismatched %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic hang(string what);
      fails++;
      $display("BAD %s expected answer seen none", what);
      results();
   endtask

   // Request held from a falling edge through the taking edge
   task automatic send(fsp_cmd_t c, logic [23:0] a, logic [15:0] d);
      int k;
      @(negedge linkClk);
      cmdValid = 1'b1;
      cmdIn = '{c, a, d};
      for (k = 0; k < 50 && cmdReady !== 1'b1; k++) @(negedge linkClk);
      if (k == 50) hang("ready");
      @(negedge linkClk);
      cmdValid = 1'b0;
      for (k = 0; k < 100 && rspValid !== 1'b1; k++) @(negedge linkClk);
      if (k == 100) hang("answer");
      rsp = rspStatus;
   endtask

   task automatic step(fsp_cmd_t c, logic [23:0] a, logic [15:0] d, logic [15:0] e,
      string what);
      int k;
      send(c, a, d);
      for (k = 0; k < 300 && statusLow[0] !== 1'b0; k++) @(negedge clk_sys);
      if (k == 300) hang("idle");
      send(STATUS_READ_CMD, 24'h000000, 16'h0000);
      check(what, rsp, e);
      check(what, {statusHigh, statusLow}, e);
      $display("done %s", what);
   endtask

   initial begin
      repeat (5) @(negedge clk_sys);
      rst_b = 1'b1;
      step(STATUS_READ_CMD, 24'h0, 16'h0, 16'h0000, "power up");
      step(STATUS_WRITE_CMD, 24'h0, 16'h001c, 16'h0000, "no latch");
      check("refused", 16'(refusals), 16'h0001);
      step(LATCH_SET_CMD, 24'h0, 16'h0, 16'h0002, "latch set");
      step(LATCH_CLEAR_CMD, 24'h0, 16'h0, 16'h0000, "latch clear");
      step(LATCH_SET_CMD, 24'h0, 16'h0, 16'h0002, "latch again");
      busyCnt = 0;
      step(STATUS_WRITE_CMD, 24'h0, 16'h1604, 16'h1604, "write");
      check("busy time", 16'(busyCnt), 16'(SR_WRITE_CYCLES));
      check("dummy", {12'h000, dualDummyCycles}, 16'h0008);
      step(LATCH_SET_CMD, 24'h0, 16'h0, 16'h1606, "latch guarded");
      step(PAGE_PROGRAM_CMD, 24'h070000, 16'h0, 16'h1606, "guarded");
      step(PAGE_PROGRAM_CMD, 24'h000000, 16'h0, 16'h1604, "open");
      step(LATCH_SET_CMD, 24'h0, 16'h0, 16'h1606, "latch chip");
      step(CHIP_ERASE_CMD, 24'h0, 16'h0, 16'h1606, "chip erase");
      step(STATUS_WRITE_CMD, 24'h0, 16'h4404, 16'h4404, "invert");
      step(LATCH_SET_CMD, 24'h0, 16'h0, 16'h4406, "latch inv");
      step(PAGE_PROGRAM_CMD, 24'h000000, 16'h0, 16'h4406, "inverted low");
      step(PAGE_PROGRAM_CMD, 24'h070000, 16'h0, 16'h4404, "inverted high");
      check("op addr", opAddr[23:8], 16'h0700);
      step(LATCH_SET_CMD, 24'h0, 16'h0, 16'h4406, "latch sec");
      step(SECURITY_PROGRAM_CMD, 24'h0, 16'h0, 16'h4406, "security");
      check("read only", {15'h0000, securityReadOnly}, 16'h0001);
      step(STATUS_WRITE_CMD, 24'h0, 16'h0084, 16'h0484, "lock kept");
      // Quad is off here, so driving the pin is safe
      @(negedge clk_sys) writeGuardB = 1'b0;
      step(LATCH_SET_CMD, 24'h0, 16'h0, 16'h0486, "latch pin");
      step(STATUS_WRITE_CMD, 24'h0, 16'h0000, 16'h0486, "pin low");
      @(negedge clk_sys) writeGuardB = 1'b1;
      step(STATUS_WRITE_CMD, 24'h0, 16'h0100, 16'h0500, "pin high");
      step(LATCH_SET_CMD, 24'h0, 16'h0, 16'h0502, "latch down");
      step(STATUS_WRITE_CMD, 24'h0, 16'h0000, 16'h0502, "lock down");
      @(negedge clk_sys) rst_b = 1'b0;
      repeat (8) @(negedge clk_sys);
      rst_b = 1'b1;
      step(STATUS_READ_CMD, 24'h0, 16'h0, 16'h0400, "power cycle");
      step(LATCH_SET_CMD, 24'h0, 16'h0, 16'h0402, "latch op");
      send(PAGE_PROGRAM_CMD, 24'h000000, 16'h0000);
      step(SUSPEND_CMD, 24'h0, 16'h0, 16'h8400, "suspend");
      step(RESUME_CMD, 24'h0, 16'h0, 16'h0400, "resume");
      step(LATCH_SET_CMD, 24'h0, 16'h0, 16'h0402, "latch ce");
      step(CHIP_ERASE_CMD, 24'h0, 16'h0, 16'h0400, "chip open");
      results();
   end
endmodule
